// *** include/asram_pkg.sv ***
// Package for the asynchronous 256K x 1 memory controller
package asram_pkg;

  localparam int ADDR_W = 18;
  localparam int CLK_PERIOD_NS = 10;

  // Slowest speed grade timing, ns
  localparam int T_ACCESS_NS = 35;
  localparam int T_WRITE_PULSE_NS = 20;
  localparam int T_DATA_SETUP_NS = 15;
  localparam int T_HIZ_NS = 15;

  localparam int ACC_CYC =
    (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRP_CYC =
    (T_WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DSU_CYC =
    (T_DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HIZ_CYC =
    (T_HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] ACC_N = CNT_W'(ACC_CYC);
  localparam logic [CNT_W-1:0] WRP_N = CNT_W'(WRP_CYC > DSU_CYC ?
                                              WRP_CYC : DSU_CYC);
  localparam logic [CNT_W-1:0] HIZ_N = CNT_W'(HIZ_CYC);

  typedef enum logic [2:0] {
    ASRAM_IDLE   = 3'b000,
    ASRAM_RSETUP = 3'b001,
    ASRAM_RWAIT  = 3'b010,
    ASRAM_WSETUP = 3'b011,
    ASRAM_WPULSE = 3'b100,
    ASRAM_RECOV  = 3'b101
  } asram_state_e;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              wdata;
  } asram_req_s;

  typedef struct packed {
    logic              sel_n;
    logic              wstb_n;
    logic [ADDR_W-1:0] addr;
    logic              din;
  } asram_pins_s;

endpackage

// *** verilog/asram_ctrl.sv ***
// Host-side controller driving a 256K x 1 asynchronous static memory
// Overview of operation
// - Read: select low, strobe high, data after access
// - Write only while select and strobe both low
// - Setup and hold relative to qualifying edges
// - Select or strobe inactive during address change
// - Address timing from last valid to first change
// - Address valid before select falls on reads
`timescale 1ns/1ps
module asram_ctrl
  import asram_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              reset_i,
  // User request
  input  wire logic              req_valid_i,
  input  wire logic              req_write_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic              req_wdata_i,
  output logic                   req_ready_o,
  // User read answer
  output logic                   rd_valid_o,
  output logic                   rd_data_o,
  // Memory pins
  output logic                   mem_sel_n_o,
  output logic                   mem_wstb_n_o,
  output logic [ADDR_W-1:0]      mem_addr_o,
  output logic                   mem_din_o,
  input  wire logic              mem_dout_i
);

  asram_state_e     state;
  asram_state_e     next_state;
  asram_req_s       req;
  asram_pins_s      pins;
  asram_pins_s      next_pins;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             dout_meta;
  logic             dout_sync;
  logic             ready;
  logic             next_ready;
  logic             rd_valid;
  logic             next_rd_valid;
  logic             rd_data;
  logic             next_rd_data;

  wire logic take     = ready && req_valid_i;
  wire logic cnt_done = (cnt == CNT_ZERO);
  wire logic [CNT_W-1:0] cnt_dec = cnt - 3'h1;

  always_comb begin
    next_state    = state;
    next_pins     = pins;
    next_cnt      = cnt_done ? CNT_ZERO : cnt_dec;
    next_ready    = 1'b0;
    next_rd_valid = 1'b0;
    next_rd_data  = rd_data;
    unique case (state)
      ASRAM_IDLE: begin
        next_ready = ~take;
        if (take) begin
          // Address settles with both controls high
          next_pins.sel_n  = 1'b1;
          next_pins.wstb_n = 1'b1;
          next_pins.addr   = req.addr;
          next_pins.din    = req.wdata;
          next_state = req.write ? ASRAM_WSETUP : ASRAM_RSETUP;
        end
      end
      ASRAM_RSETUP: begin
        // Address valid before select falls, strobe high
        next_pins.sel_n = 1'b0;
        next_cnt   = ACC_N + 3'h2;
        next_state = ASRAM_RWAIT;
      end
      ASRAM_RWAIT: begin
        // Wait access plus synchroniser depth
        if (cnt_done) begin
          next_rd_data    = dout_sync;
          next_rd_valid   = 1'b1;
          next_pins.sel_n = 1'b1;
          next_cnt   = HIZ_N;
          next_state = ASRAM_RECOV;
        end
      end
      ASRAM_WSETUP: begin
        // Select and strobe fall together; write starts on overlap
        next_pins.sel_n  = 1'b0;
        next_pins.wstb_n = 1'b0;
        next_cnt   = WRP_N;
        next_state = ASRAM_WPULSE;
      end
      ASRAM_WPULSE: begin
        if (cnt_done) begin
          // Select rises with strobe: ends write, output stays off
          next_pins.sel_n  = 1'b1;
          next_pins.wstb_n = 1'b1;
          next_cnt   = CNT_ZERO;
          next_state = ASRAM_RECOV;
        end
      end
      ASRAM_RECOV: begin
        // Address and data held one cycle after a write ends, three cycles after a read
        if (cnt_done) begin
          next_ready = 1'b1;
          next_state = ASRAM_IDLE;
        end
      end
      default: begin
        next_state = ASRAM_IDLE;
        next_pins.sel_n  = 1'b1;
        next_pins.wstb_n = 1'b1;
      end
    endcase
  end

  // Data output from the memory is asynchronous
  always_ff @(posedge mclk_i) begin
    dout_meta <= mem_dout_i;
    dout_sync <= dout_meta;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state    <= ASRAM_IDLE;
      pins     <= '{sel_n: 1'b1, wstb_n: 1'b1, addr: '0, din: 1'b0};
      cnt      <= CNT_ZERO;
      ready    <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= 1'b0;
    end else begin
      state    <= next_state;
      pins     <= next_pins;
      cnt      <= next_cnt;
      ready    <= next_ready;
      rd_valid <= next_rd_valid;
      rd_data  <= next_rd_data;
    end
  end

  assign req = '{write: req_write_i, addr: req_addr_i, wdata: req_wdata_i};

  assign req_ready_o  = ready;
  assign rd_valid_o   = rd_valid;
  assign rd_data_o    = rd_data;
  assign mem_sel_n_o  = pins.sel_n;
  assign mem_wstb_n_o = pins.wstb_n;
  assign mem_addr_o   = pins.addr;
  assign mem_din_o    = pins.din;

endmodule

// *** sim/asram_mem_model.sv ***
// Behavioural model of the 256K x 1 asynchronous memory
`timescale 1ns/1ps
module asram_mem_model
  import asram_pkg::*;
(
  // Memory pins
  input  wire logic              sel_n_i,
  input  wire logic              wstb_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              din_i,
  output logic                   dout_o
);
  logic bits [0:(1<<ADDR_W)-1];
  wire logic wr_on = !sel_n_i && !wstb_n_i;
  wire logic rd_on = !sel_n_i && wstb_n_i;
  initial dout_o = 1'h0;
  // Commit when either control rises
  always @(negedge wr_on) bits[addr_i] = din_i;
  // Floating output shows a changed level, sooner than enable
  always @(rd_on, addr_i)
    if (rd_on) dout_o <= #T_ACCESS_NS bits[addr_i];
    else dout_o <= #5 ~dout_o;
  // Wake-up tracking; idles after the powerdown delay
  localparam int POWERDOWN_DELAY_NS = 35;
  logic active_power_state = 1'b0;
  int   wakes = 0;
  always @(sel_n_i, wstb_n_i, addr_i, din_i)
    if (!sel_n_i) begin
      wakes++;
      active_power_state = 1'b1;
      fork
        begin
          automatic int seen = wakes;
          #POWERDOWN_DELAY_NS;
          if (seen == wakes) active_power_state = 1'b0;
        end
      join_none
    end
endmodule

// *** sim/asram_ctrl_assertions.sv ***
// Port checks on the memory controller
`timescale 1ns/1ps
module asram_ctrl_assertions
  import asram_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              reset_i,
  input wire logic              req_valid_i,
  input wire logic              req_write_i,
  input wire logic              req_ready_o,
  input wire logic              rd_valid_o,
  input wire logic              mem_sel_n_o,
  input wire logic              mem_wstb_n_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic              mem_din_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  wire logic tk = req_valid_i && req_ready_o;
  property p_rd; tk && !req_write_i |-> ##9 rd_valid_o; endproperty
  a_rd: assert property (p_rd) else $error("read late");
  property p_cs; tk && !req_write_i |-> ##2 $fell(mem_sel_n_o); endproperty
  a_cs: assert property (p_cs) else $error("select late");
  property p_wf; $fell(mem_wstb_n_o) |-> $fell(mem_sel_n_o); endproperty
  a_wf: assert property (p_wf) else $error("strobe alone");
  property p_wr; $rose(mem_wstb_n_o) |-> $rose(mem_sel_n_o); endproperty
  a_wr: assert property (p_wr) else $error("end split");
  property p_wp;
    $fell(mem_wstb_n_o) |-> !mem_wstb_n_o[*3] ##1 mem_wstb_n_o;
  endproperty
  a_wp: assert property (p_wp) else $error("pulse width");
  property p_as; !mem_sel_n_o |-> $stable(mem_addr_o); endproperty
  a_as: assert property (p_as) else $error("addr moved");
  property p_ds; !mem_wstb_n_o |-> $stable(mem_din_o); endproperty
  a_ds: assert property (p_ds) else $error("data moved");
  property p_wy;
    tk && req_write_i |=> !req_ready_o[*5] ##1 req_ready_o;
  endproperty
  a_wy: assert property (p_wy) else $error("write cycle");
  c_w: cover property (tk && req_write_i);
  c_r: cover property (tk && !req_write_i);
  c_v: cover property (rd_valid_o);
endmodule
bind asram_ctrl asram_ctrl_assertions chk (.*);

// *** sim/asram_ctrl_test.sv ***
// Self-checking bench for the memory controller
`timescale 1ns/1ps
module asram_ctrl_test
  import asram_pkg::*;
;
  logic mclk_i = 0, reset_i = 1, req_valid_i = 0, req_write_i = 0;
  logic [ADDR_W-1:0] req_addr_i = '0, mem_addr_o;
  logic req_wdata_i = 0, req_ready_o, rd_valid_o, rd_data_o;
  logic mem_sel_n_o, mem_wstb_n_o, mem_din_o, mem_dout_i;
  logic exp_q[$];
  logic ref_m[int];
  logic [ADDR_W-1:0] a[6];
  int miscompares = 0, checks_done = 0, i;
  asram_ctrl dut (.*);
  asram_mem_model mem (.sel_n_i(mem_sel_n_o), .wstb_n_i(mem_wstb_n_o),
    .addr_i(mem_addr_o), .din_i(mem_din_o), .dout_o(mem_dout_i));
  initial forever #5 mclk_i = ~mclk_i;
  task automatic complete_run;
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic e, input logic s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %b got %b", n, e, s);
    end
  endtask
  // Request held until taken; fields then change while refused
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad,
                      input logic d);
    int n = 0;
    req_valid_i = 1;
    req_write_i = w;
    req_addr_i = ad;
    req_wdata_i = d;
    do begin
      @(posedge mclk_i);
      n++;
    end while (req_ready_o !== 1'h1 && n < 50);
    if (req_ready_o !== 1'h1) begin
      miscompares++;
      complete_run;
    end
    if (w) ref_m[ad] = d;
    else exp_q.push_back(ref_m[ad]);
    @(negedge mclk_i);
  endtask
  always @(posedge mclk_i)
    if (rd_valid_o === 1'h1 && exp_q.size() > 0)
      chk("rd_data", exp_q.pop_front(), rd_data_o);
  initial begin
    i = $urandom(34);
    repeat (10) @(negedge mclk_i);
    reset_i = 0;
    a[0] = 18'h00000;
    a[1] = 18'h3FFFF;
    for (i = 2; i < 6; i++) a[i] = ADDR_W'($urandom);
    for (i = 0; i < 12; i++) xfer(1, a[i % 6], 1'($urandom));
    for (i = 0; i < 6; i++) xfer(0, a[i], 0);
    for (i = 0; i < 4; i++) begin
      xfer(1, a[1], i[0]);
      xfer(0, a[1], 0);
    end
    req_valid_i = 0;
    repeat (20) @(negedge mclk_i);
    chk("pending", 1'h0, exp_q.size() != 0);
    chk("idle_power", 1'h0, mem.active_power_state);
    complete_run;
  end
endmodule
